/* File: core/bcr_pkg.sv */
// Constants and types for the step-down converter control register bank.
// Assumes the register port is driven by the device's internal serial engine.
`default_nettype none
package bcr_pkg;
	// ==========================================================
	// Register map (byte addresses on the internal register port)
	localparam logic [7:0] ADDR_CONV1_SETTING_A     = 8'h10;
	localparam logic [7:0] ADDR_CONV1_SETTING_B     = 8'h11;
	localparam logic [7:0] ADDR_CONV1_STANDBY_VOLT  = 8'h12;
	localparam logic [7:0] ADDR_CONV2_SETTING_A     = 8'h13;
	localparam logic [7:0] ADDR_CONV2_SETTING_B     = 8'h14;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_CONV1_SETTING_A    = 8'h10; // 1.24 V code
	localparam logic [7:0] RST_CONV1_SETTING_B    = 8'h16; // 180 deg, 15.36
	localparam logic [7:0] RST_CONV1_STANDBY_VOLT = 8'h10; // 1.24 V code
	localparam logic [7:0] RST_CONV2_SETTING_A    = 8'h0a; // 1.80 V code
	localparam logic [7:0] RST_CONV2_SETTING_B    = 8'h06; // 15.36

	// ==========================================================
	// Field positions, setting A
	localparam int A_ON_BIT      = 7;
	localparam int A_RIPPLE_BIT  = 6;
	localparam int A_LIGHT_BIT   = 5;
	localparam int VCODE_MSB     = 4;
	// Field positions, setting B
	localparam int B_SLEEP_BIT   = 6;
	localparam int B_DRAIN_BIT   = 5;
	localparam int B_PHASE_MSB   = 4;
	localparam int B_PHASE_LSB   = 3;
	localparam int B_RAMP_MSB    = 2;
	localparam logic [7:0] STANDBY_WR_MASK = 8'h1f;
	localparam logic [2:0] RAMP_IMMEDIATE  = 3'h7;

	// ==========================================================
	// Timing: one code step at the slowest ramp rate
	localparam int CLK_MHZ          = 20;
	localparam int STEP_UV          = 40000; // First converter code step
	localparam int RAMP_BASE_UV_US  = 240;   // 0.24 mV/us slowest rate
	localparam int RAMP_BASE_CYC    = STEP_UV * CLK_MHZ / RAMP_BASE_UV_US;
	localparam int PHASE_STEPS      = 4;

	// Per-converter control bundle
	typedef struct packed {
		logic       on;
		logic       ripple_hi;
		logic       fixed_freq_only;
		logic       pulse_skip_mode;
		logic       sleep;
		logic       drain;
		logic       ramping;
		logic [4:0] vcode;
	} bcr_buck_ctrl_s;
endpackage : bcr_pkg
`default_nettype wire

/* File: core/bcr_regs.sv */
// Control register bank and ramp/phase logic for two step-down converters.
// Assumes a byte-wide register port from the internal serial engine, same clock.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RULE1 - First converter registers at 10h-12h, second from 13h.
// RULE2 - Each bit honours its access; both setting registers fully RW.
// RULE3 - Phase field delays second clock by 0, 90, 180 or 270 degrees.
// RULE4 - Phase field resets to code 10, a 180 degree delay.
// RULE5 - Ramp field doubles rate per code from 0.24 mV/us; 111 is immediate.
// RULE6 - First converter ramp field resets to 15.36 mV/us.
// RULE7 - Separate standby code sets first converter target in standby.
// RULE8 - Standby register bits 4-0 writable, 7-5 read zero; resets to 1.24 V.
// RULE9 - Light-load bit clear allows automatic fixed/pulse-skip switching.
// RULE10 - Ripple bit low saves comparator current; high cuts ripple.
// RULE11 - In standby the converter pulse-skips at its standby voltage; the second converter pulse-skips at its normal code.
// RULE12 - Target changes step the output at the selected rate, or one step.
// RULE13 - Bit 7 of setting A switches the converter on when set.
// RULE14 - Light-load bit forces fixed frequency; standby and drain bits act.
module bcr_regs
	import bcr_pkg::*;
#(
	parameter int PWM_DIV = 20
)(
	// Clock and reset
	input  wire logic            i_mclk,
	input  wire logic            i_srst,
	// Register port
	input  wire logic            i_wr_en,
	input  wire logic            i_rd_en,
	input  wire logic [7:0]      i_addr,
	input  wire logic [7:0]      i_wdata,
	output var  logic [7:0]      o_rdata,
	output var  logic            o_rd_valid,
	// Converter controls
	output var  bcr_buck_ctrl_s  o_first_buck,
	output var  bcr_buck_ctrl_s  o_second_buck,
	// Switching clock sync pulses
	output var  logic            o_first_sync,
	output var  logic            o_second_sync
);

	// ==========================================================
	// Register storage
	logic [7:0]      set_a_q [2];
	logic [7:0]      set_b_q [2];
	logic [4:0]      stby_q;
	logic [7:0]      rdata_q;
	logic            rd_valid_q;
	bcr_buck_ctrl_s  ctrl_q [2];
	logic [4:0]      cur_q [2];
	logic [11:0]     tmr_q [2];
	logic [4:0]      tgt [2];
	logic [2:0]      ramp [2];
	logic [11:0]     reload [2];

	// Host writes; unmapped addresses are ignored
	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			set_a_q[0] <= RST_CONV1_SETTING_A; // RULE4 RULE6
			set_b_q[0] <= RST_CONV1_SETTING_B; // RULE4 RULE6
			stby_q     <= RST_CONV1_STANDBY_VOLT[4:0]; // RULE8
			set_a_q[1] <= RST_CONV2_SETTING_A;
			set_b_q[1] <= RST_CONV2_SETTING_B;
		end
		else if (i_wr_en)
		begin
			case (i_addr) // RULE1 RULE2
				ADDR_CONV1_SETTING_A:    set_a_q[0] <= i_wdata;
				ADDR_CONV1_SETTING_B:    set_b_q[0] <= i_wdata;
				ADDR_CONV1_STANDBY_VOLT: stby_q <= i_wdata[4:0]; // RULE8
				ADDR_CONV2_SETTING_A:    set_a_q[1] <= i_wdata;
				ADDR_CONV2_SETTING_B:    set_b_q[1] <= i_wdata;
				default:                 ;
			endcase
		end
	end

	// Host reads, answered one cycle later; unmapped reads return zero
	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			rdata_q    <= 8'h00;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			rd_valid_q <= i_rd_en;
			if (i_rd_en)
			begin
				case (i_addr) // RULE1 RULE2
					ADDR_CONV1_SETTING_A:    rdata_q <= set_a_q[0];
					ADDR_CONV1_SETTING_B:    rdata_q <= set_b_q[0];
					ADDR_CONV1_STANDBY_VOLT: rdata_q <= {3'h0, stby_q}; // RULE8
					ADDR_CONV2_SETTING_A:    rdata_q <= set_a_q[1];
					ADDR_CONV2_SETTING_B:    rdata_q <= set_b_q[1];
					default:                 rdata_q <= 8'h00;
				endcase
			end
		end
	end

	assign o_rdata    = rdata_q;
	assign o_rd_valid = rd_valid_q;

	// ==========================================================
	// Per-converter target, ramp and control outputs
	for (genvar g = 0; g < 2; g++)
	begin : g_conv
		logic sleep;
		assign sleep = set_b_q[g][B_SLEEP_BIT];
		// Only the first converter has a standby code register here
		assign tgt[g] = (g == 0 && sleep) ? stby_q // RULE7 RULE11
			: set_a_q[g][VCODE_MSB:0];
		assign ramp[g] = set_b_q[g][B_RAMP_MSB:0];
		// Slowest rate needs the full count; each code halves it
		assign reload[g] = 12'(RAMP_BASE_CYC >> ramp[g]) - 12'h001; // RULE5

		// Step one code at a time toward target; immediate rate jumps to it
		always_ff @(posedge i_mclk)
		begin
			if (i_srst)
			begin
				cur_q[g] <= (g == 0) ? RST_CONV1_SETTING_A[4:0]
					: RST_CONV2_SETTING_A[4:0];
				tmr_q[g] <= 12'h000;
			end
			else if (ramp[g] == RAMP_IMMEDIATE)
			begin
				cur_q[g] <= tgt[g]; // RULE5 RULE12
				tmr_q[g] <= 12'h000;
			end
			else if (cur_q[g] == tgt[g])
				tmr_q[g] <= reload[g]; // Restart interval on next change
			else if (tmr_q[g] == 12'h000 || tmr_q[g] > reload[g])
			begin
				// Faster rate chosen mid-ramp with count above its reload also steps at once
				cur_q[g] <= (cur_q[g] < tgt[g]) ? cur_q[g] + 5'h01
					: cur_q[g] - 5'h01; // RULE12
				tmr_q[g] <= reload[g];
			end
			else
				tmr_q[g] <= tmr_q[g] - 12'h001;
		end

		// Registered control bundle to the analog side
		always_ff @(posedge i_mclk)
		begin
			if (i_srst)
				ctrl_q[g] <= '0;
			else
			begin
				ctrl_q[g].on              <= set_a_q[g][A_ON_BIT]; // RULE13
				ctrl_q[g].ripple_hi       <= set_a_q[g][A_RIPPLE_BIT]; // RULE10
				// Standby overrides the forced fixed-frequency setting
				ctrl_q[g].fixed_freq_only <= set_a_q[g][A_LIGHT_BIT]
					& ~sleep; // RULE9 RULE14
				ctrl_q[g].pulse_skip_mode <= sleep; // RULE11
				ctrl_q[g].sleep           <= sleep; // RULE14
				ctrl_q[g].drain           <= set_b_q[g][B_DRAIN_BIT]; // RULE14
				ctrl_q[g].ramping         <= (cur_q[g] != tgt[g]);
				ctrl_q[g].vcode           <= cur_q[g]; // RULE12
			end
		end
	end

	assign o_first_buck  = ctrl_q[0];
	assign o_second_buck = ctrl_q[1];

	// ==========================================================
	// Switching clock phase: second sync lags first by phase quarters
	logic [15:0] ph_q;
	logic [15:0] ph_off;
	logic        sync1_q;
	logic        sync2_q;

	assign ph_off = 16'((32'(set_b_q[0][B_PHASE_MSB:B_PHASE_LSB]) * PWM_DIV)
		/ PHASE_STEPS); // RULE3

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			ph_q    <= 16'h0000;
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end
		else
		begin
			ph_q    <= (ph_q == 16'(PWM_DIV - 1)) ? 16'h0000 : ph_q + 16'h0001;
			sync1_q <= (ph_q == 16'h0000);
			sync2_q <= (ph_q == ph_off); // RULE3
		end
	end

	assign o_first_sync  = sync1_q;
	assign o_second_sync = sync2_q;

endmodule : bcr_regs
`default_nettype wire

/* File: verification/bcr_host.sv */
// Host model: drives the byte register port of the bank.
// Assumes one clock; requests change on falling edges.
`timescale 1ns/100ps
`default_nettype none
module bcr_host (
	// Clock
	input  wire logic       i_mclk,
	// Register port
	output var  logic       o_wr_en,
	output var  logic       o_rd_en,
	output var  logic [7:0] o_addr,
	output var  logic [7:0] o_wdata,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rd_valid
);
	// =====
	// Idle port at time zero
	initial {o_wr_en, o_rd_en, o_addr, o_wdata} = '0;
	// Write strobe for one rising edge; data inverted once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_mclk) {o_wr_en, o_addr, o_wdata} = {1'b1, a, d};
		@(negedge i_mclk) {o_wr_en, o_wdata} = {1'b0, ~d};
	endtask : wr
	// Read strobe; data only trusted while valid is up
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_mclk) {o_rd_en, o_addr} = {1'b1, a};
		@(negedge i_mclk) o_rd_en = 1'b0;
		d = (i_rd_valid === 1'b1) ? i_rdata : 8'hxx;
	endtask : rd
endmodule : bcr_host
`default_nettype wire

/* File: verification/bcr_regs_checker.sv */
// Checker: register port and control relations of the bank.
// Assumes it is bound onto bcr_regs.
`timescale 1ns/100ps
`default_nettype none
module bcr_regs_checker
	import bcr_pkg::*;
#(
	parameter int PWM_DIV = 20
)(
	// Clock, reset and register port
	input wire logic           i_mclk,
	input wire logic           i_srst,
	input wire logic           i_wr_en,
	input wire logic           i_rd_en,
	input wire logic [7:0]     i_addr,
	input wire logic [7:0]     i_wdata,
	input wire logic [7:0]     o_rdata,
	input wire logic           o_rd_valid,
	// Controls and sync
	input wire bcr_buck_ctrl_s o_first_buck,
	input wire logic           o_first_sync
);
	// =====
	// One domain, so clock and reset are given once
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	// Lone write to 10h; a second one would move the result
	sequence wr_on;
		i_wr_en && i_addr == 8'h10 ##1 !(i_wr_en && i_addr == 8'h10);
	endsequence
	rd_pulse_a: assert property (i_rd_en |=> o_rd_valid)
		else $error("read not answered");
	rd_hold_a: assert property (!$past(i_rd_en) |-> $stable(o_rdata))
		else $error("read data moved");
	unmapped_zero_a: assert property (i_rd_en &&
		(i_addr < 8'h10 || i_addr > 8'h14) |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	standby_top_a: assert property (i_rd_en && i_addr == 8'h12
		|=> o_rdata[7:5] == 3'h0) else $error("standby top bits set");
	sleep_skip_a: assert property (o_first_buck.sleep |->
		o_first_buck.pulse_skip_mode && !o_first_buck.fixed_freq_only)
		else $error("standby not pulse skipping");
	on_write_a: assert property (wr_on |=>
		o_first_buck.on == $past(i_wdata[7], 2)) else $error("on bit wrong");
	sync_period_a: assert property (o_first_sync |->
		##PWM_DIV o_first_sync) else $error("sync period wrong");
	sync_gap_a: assert property (o_first_sync |=> !o_first_sync [*3])
		else $error("sync too frequent");
	// Main scenarios reached
	cover property (o_rd_valid && o_rdata == 8'h1f);
	cover property (o_first_buck.sleep);
	cover property (wr_on);
	cover property (o_first_buck.ramping);
endmodule : bcr_regs_checker
bind bcr_regs bcr_regs_checker #(.PWM_DIV(PWM_DIV)) bcr_regs_checker_i (
	.i_mclk, .i_srst, .i_wr_en, .i_rd_en, .i_addr, .i_wdata,
	.o_rdata, .o_rd_valid, .o_first_buck, .o_first_sync);
`default_nettype wire

/* File: verification/bcr_regs_test.sv */
// Testbench: register access, controls and clock phase of the bank.
// Assumes the host model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module bcr_regs_test;
	import bcr_pkg::*;
	logic mclk = 1'b0, srst = 1'b1, wr_en, rd_en, rd_valid, s1, s2;
	logic [7:0] addr, wdata, rdata, d;
	bcr_buck_ctrl_s b1, b2;
	int num_errors = 0, cmp_count = 0, n;
	localparam logic [7:0] RV [5] = '{8'h10, 8'h16, 8'h10, 8'h0a, 8'h06};
	// =====
	// 20 MHz clock
	always #25 mclk = ~mclk;
	bcr_regs #(.PWM_DIV(20)) bcr_regs_i (.i_mclk(mclk), .i_srst(srst),
		.i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata),
		.o_rdata(rdata), .o_rd_valid(rd_valid), .o_first_buck(b1),
		.o_second_buck(b2), .o_first_sync(s1), .o_second_sync(s2));
	bcr_host bcr_host_i (.i_mclk(mclk), .o_wr_en(wr_en), .o_rd_en(rd_en),
		.o_addr(addr), .o_wdata(wdata), .i_rdata(rdata),
		.i_rd_valid(rd_valid));
	// Compare one byte result
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// Verdict and end of run
	task automatic complete_run;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run
	// Hang guard, far above the fewer than a thousand cycles needed
	initial
	begin
		#2000000;
		num_errors++;
		complete_run();
	end
	// Main sequence
	initial
	begin
		repeat (4) @(negedge mclk);
		srst = 1'b0;
		for (int i = 0; i < 5; i++)
		begin
			bcr_host_i.rd(8'h10 + 8'(i), d);
			chk("reset", RV[i], d);
			bcr_host_i.wr(8'h10 + 8'(i), 8'hff);
			bcr_host_i.rd(8'h10 + 8'(i), d);
			chk("rw", (i == 2) ? 8'h1f : 8'hff, d);
		end
		bcr_host_i.wr(8'h15, 8'h5a);
		bcr_host_i.rd(8'h15, d);
		chk("unmapped", 8'h00, d);
		// Second converter: standby forces pulse skip, normal code kept
		chk("second ctl", 8'h6e, {1'b0, b2[11:5]});
		chk("second code", 8'h1f, {3'h0, b2.vcode});
		// Immediate ramp, so targets land within a few cycles
		bcr_host_i.wr(8'h10, 8'hfa);
		bcr_host_i.wr(8'h11, 8'h07);
		repeat (4) @(negedge mclk);
		chk("ctl", {b1.on, b1.ripple_hi, b1.fixed_freq_only, b1.vcode},
			8'hfa);
		bcr_host_i.wr(8'h12, 8'h05);
		bcr_host_i.wr(8'h11, 8'h47);
		repeat (4) @(negedge mclk);
		chk("sleep", {b1.on, b1.ripple_hi, b1.fixed_freq_only, b1.vcode},
			8'hc5);
		// Each phase code: cycles from first to second sync
		for (int p = 0; p < 4; p++)
		begin
			bcr_host_i.wr(8'h11, {3'h0, 2'(p), 3'h7});
			repeat (60) @(negedge mclk);
			while (s1 !== 1'b1) @(negedge mclk);
			n = 0;
			while (s2 !== 1'b1)
			begin
				n++;
				@(negedge mclk);
			end
			chk("phase", 8'(p * 5), 8'(n));
		end
		// Two slow ramp codes through 19h; code 5 steps half as fast
		for (int c = 6; c >= 5; c--)
		begin
			bcr_host_i.wr(8'h11, 8'h20 | 8'(c));
			bcr_host_i.wr(8'h10, (c == 6) ? 8'h98 : 8'h9a);
			while (b1.vcode !== 5'h19) @(negedge mclk);
			chk("ramping", 8'h01, {7'h0, b1.ramping});
			n = 0;
			while (b1.vcode !== ((c == 6) ? 5'h18 : 5'h1a))
			begin
				n++;
				@(negedge mclk);
			end
			chk("ramp", 8'(RAMP_BASE_CYC >> c), 8'(n));
		end
		chk("drain", 8'h01, {7'h0, b1.drain});
		chk("ramp idle", 8'h00, {7'h0, b1.ramping});
		complete_run();
	end
endmodule : bcr_regs_test
`default_nettype wire
